/* File: logic/dac_power_fault_control.sv */
// power control register and fault reactions of a quad output converter
`timescale 1ns/1ps
`default_nettype none
module dac_power_fault_control
   import dac_pwr_pkg::*;
(
   // system clock and reset
   input  wire logic       SYS_CLK,
   input  wire logic       RESET,
   // serial link
   input  wire logic       SCLK,
   input  wire logic       SYNC_N,
   input  wire logic       SDIN,
   output logic            SDO,
   output logic            SDO_OE,
   // analog status inputs
   input  wire logic [3:0] OVERCURRENT,
   input  wire logic       OVERTEMP,
   input  wire logic       SUPPLY_OK,
   // analog controls
   output logic [3:0]      CHAN_POWERED,
   output logic [3:0]      AMP_CONNECT,
   output logic [3:0]      OUT_CLAMP,
   output logic [3:0]      CURRENT_LIMIT,
   output logic            REF_POWERED
);
   // ****************************************
   // declarations
   // ****************************************
   logic [FRAME_BITS-1:0] rx_word;
   logic                  rx_tog;
   logic                  tog_s;
   logic [5:0]            ana_s;
   logic [3:0]            oc_s;
   logic                  ot_s;
   logic                  sup_s;
   logic                  tog_seen_r;
   logic                  tog_seen_nxt;
   logic [3:0]            pu_r;
   logic [3:0]            pu_nxt;
   logic                  ref_r;
   logic                  ref_nxt;
   logic                  clamp_r;
   logic                  clamp_nxt;
   logic                  tsd_en_r;
   logic                  tsd_en_nxt;
   logic                  sdo_dis_r;
   logic                  sdo_dis_nxt;
   logic                  armed_r;
   logic                  armed_nxt;
   logic                  ot_alert_r;
   logic                  ot_alert_nxt;
   logic [3:0]            oc_r;
   logic [3:0]            oc_nxt;
   logic [FRAME_BITS-1:0] rb_r;
   logic [FRAME_BITS-1:0] rb_nxt;
   logic                  new_frame;
   logic                  is_wr;
   logic [2:0]            reg_sel;
   logic [2:0]            addr;
   logic [DATA_W-1:0]     data;
   logic                  shutdown;

   function automatic logic [DATA_W-1:0] power_word(
      input logic [3:0] oc,
      input logic       ot,
      input logic       rf,
      input logic [3:0] pu
   );
      logic [DATA_W-1:0] w;
      w                           = '0;
      w[OC_LO_POS +: 4]           = oc;
      w[OT_POS]                   = ot;
      w[REF_POS]                  = rf;
      w[PU_LO_POS +: 4]           = pu;
      return w;
   endfunction : power_word

   // ****************************************
   // link domain and crossings
   // ****************************************
   frame_rx u_rx (
      .sclk     (SCLK),
      .sync_n   (SYNC_N),
      .sdin     (SDIN),
      .sdo      (SDO),
      .rst      (RESET),
      .rb_word  (rb_r),
      .word     (rx_word),
      .word_tog (rx_tog)
   );

   level_sync #(.W(1)) u_tog_sync (
      .clk (SYS_CLK),
      .rst (RESET),
      .d   (rx_tog),
      .q   (tog_s)
   );

   level_sync #(.W(6)) u_ana_sync (
      .clk (SYS_CLK),
      .rst (RESET),
      .d   ({SUPPLY_OK, OVERTEMP, OVERCURRENT}),
      .q   (ana_s)
   );

   assign oc_s  = ana_s[3:0];
   assign ot_s  = ana_s[4];
   assign sup_s = ana_s[5];

   // ****************************************
   // frame decode
   // ****************************************
   assign new_frame = tog_s ^ tog_seen_r;
   assign is_wr     = ~rx_word[RW_POS];
   assign reg_sel   = rx_word[REG_HI_POS:REG_LO_POS];
   assign addr      = rx_word[ADDR_HI_POS:ADDR_LO_POS];
   assign data      = rx_word[DATA_W-1:0];
   assign shutdown  = tsd_en_r & ot_s;

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      tog_seen_nxt = tog_s;
      pu_nxt       = pu_r;
      ref_nxt      = ref_r;
      clamp_nxt    = clamp_r;
      tsd_en_nxt   = tsd_en_r;
      sdo_dis_nxt  = sdo_dis_r;
      armed_nxt    = armed_r;
      rb_nxt       = rb_r;
      if (new_frame && is_wr) begin
         if (reg_sel == REG_POWER && addr == ADDR_POWER) begin
            pu_nxt  = data[PU_LO_POS +: 4];
            ref_nxt = data[REF_POS];
         end
         if (reg_sel == REG_CONTROL && addr == ADDR_CFG) begin
            clamp_nxt   = data[CLAMP_POS];
            tsd_en_nxt  = data[TSD_EN_POS];
            sdo_dis_nxt = data[SDO_DIS_POS];
         end
         if (reg_sel == REG_DAC && sup_s) begin
            armed_nxt = 1'b1;
         end
      end
      if (new_frame && !is_wr) begin
         rb_nxt = '0;
         rb_nxt[FRAME_BITS-1:DATA_W] = rx_word[FRAME_BITS-1:DATA_W];
         if (reg_sel == REG_POWER) begin
            rb_nxt[DATA_W-1:0] = power_word(oc_r, ot_alert_r, ref_r, pu_r);
         end else if (reg_sel == REG_CONTROL) begin
            rb_nxt[TSD_EN_POS]  = tsd_en_r;
            rb_nxt[CLAMP_POS]   = clamp_r;
            rb_nxt[SDO_DIS_POS] = sdo_dis_r;
         end
      end
      if (!clamp_r) begin
         pu_nxt = pu_nxt & ~oc_s;
      end
      if (shutdown) begin
         pu_nxt = '0;
      end
      if (!sup_s) begin
         armed_nxt = 1'b0;
      end
      oc_nxt       = oc_s;
      ot_alert_nxt = shutdown | (ot_alert_r & ot_s);
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         tog_seen_r <= 1'b0;
         pu_r       <= PU_RST;
         ref_r      <= REF_RST;
         clamp_r    <= CLAMP_RST;
         tsd_en_r   <= TSD_EN_RST;
         sdo_dis_r  <= SDO_DIS_RST;
         armed_r    <= 1'b0;
         ot_alert_r <= 1'b0;
         oc_r       <= '0;
         rb_r       <= '0;
      end else begin
         tog_seen_r <= tog_seen_nxt;
         pu_r       <= pu_nxt;
         ref_r      <= ref_nxt;
         clamp_r    <= clamp_nxt;
         tsd_en_r   <= tsd_en_nxt;
         sdo_dis_r  <= sdo_dis_nxt;
         armed_r    <= armed_nxt;
         ot_alert_r <= ot_alert_nxt;
         oc_r       <= oc_nxt;
         rb_r       <= rb_nxt;
      end
   end

   // ****************************************
   // analog controls
   // ****************************************
   assign CHAN_POWERED  = pu_r;
   assign AMP_CONNECT   = pu_r & {4{armed_r}};
   assign OUT_CLAMP     = ~(pu_r & {4{armed_r}});
   assign CURRENT_LIMIT = oc_r & {4{clamp_r}};
   assign REF_POWERED   = ref_r;
   assign SDO_OE        = ~SYNC_N & ~sdo_dis_r;
endmodule : dac_power_fault_control
`default_nettype wire

/* File: logic/dac_pwr_pkg.sv */
// constants shared by the power and fault supervision block
package dac_pwr_pkg;
   // ****************************************
   // frame layout
   // ****************************************
   localparam int          FRAME_BITS  = 24;
   localparam int          CNT_W       = 5;
   localparam int          RW_POS      = 23;
   localparam int          REG_HI_POS  = 21;
   localparam int          REG_LO_POS  = 19;
   localparam int          ADDR_HI_POS = 18;
   localparam int          ADDR_LO_POS = 16;
   localparam int          DATA_W      = 16;
   // ****************************************
   // register selects and register addresses
   // ****************************************
   localparam logic [2:0]  REG_DAC     = 3'h0;
   localparam logic [2:0]  REG_POWER   = 3'h2;
   localparam logic [2:0]  REG_CONTROL = 3'h3;
   localparam logic [2:0]  ADDR_POWER  = 3'h0;
   localparam logic [2:0]  ADDR_CFG    = 3'h1;
   // ****************************************
   // power control fields
   // ****************************************
   localparam int          PU_LO_POS   = 0;
   localparam int          REF_POS     = 4;
   localparam int          OT_POS      = 5;
   localparam int          OC_LO_POS   = 7;
   // ****************************************
   // control configuration fields
   // ****************************************
   localparam int          SDO_DIS_POS = 0;
   localparam int          CLAMP_POS   = 2;
   localparam int          TSD_EN_POS  = 3;
   // ****************************************
   // values after reset
   // ****************************************
   localparam logic [3:0]  PU_RST      = 4'h0;
   localparam logic        REF_RST     = 1'b0;
   localparam logic        CLAMP_RST   = 1'b1;
   localparam logic        TSD_EN_RST  = 1'b0;
   localparam logic        SDO_DIS_RST = 1'b0;
   // ****************************************
   // power-up wait the host keeps
   // ****************************************
   localparam int          SYS_CLK_HZ     = 10_000_000;
   localparam int          PU_WAIT_US     = 10;
   localparam int          PU_WAIT_CYCLES = (PU_WAIT_US * (SYS_CLK_HZ / 1_000_000));
endpackage : dac_pwr_pkg

/* File: logic/frame_rx.sv */
// serial frame capture and readback shift-out on the link clock
`timescale 1ns/1ps
`default_nettype none
module frame_rx
   import dac_pwr_pkg::*;
(
   // link
   input  wire logic                  sclk,
   input  wire logic                  sync_n,
   input  wire logic                  sdin,
   output logic                       sdo,
   // from system domain
   input  wire logic                  rst,
   input  wire logic [FRAME_BITS-1:0] rb_word,
   // to system domain
   output logic [FRAME_BITS-1:0]      word,
   output logic                       word_tog
);
   logic [CNT_W-1:0]      cnt_r;
   logic [CNT_W-1:0]      cnt_nxt;
   logic [FRAME_BITS-1:0] sh_r;
   logic [FRAME_BITS-1:0] sh_nxt;
   logic [FRAME_BITS-1:0] word_r;
   logic [FRAME_BITS-1:0] word_nxt;
   logic                  tog_r;
   logic                  tog_nxt;
   logic [CNT_W-1:0]      idx;

   // ****************************************
   // bit counter, cleared between frames
   // ****************************************
   always_comb begin
      cnt_nxt = cnt_r;
      if (cnt_r != CNT_W'(FRAME_BITS)) begin
         cnt_nxt = cnt_r + CNT_W'(1);
      end
   end

   always_ff @(negedge sclk or posedge sync_n) begin
      if (sync_n) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   // ****************************************
   // shift in, capture on the last bit
   // ****************************************
   always_comb begin
      sh_nxt   = {sh_r[FRAME_BITS-2:0], sdin};
      word_nxt = word_r;
      tog_nxt  = tog_r;
      if (cnt_r == CNT_W'(FRAME_BITS - 1)) begin
         word_nxt = sh_nxt;
         tog_nxt  = ~tog_r;
      end
   end

   always_ff @(negedge sclk or posedge rst) begin
      if (rst) begin
         sh_r   <= '0;
         word_r <= '0;
         tog_r  <= 1'b0;
      end else begin
         sh_r   <= sh_nxt;
         word_r <= word_nxt;
         tog_r  <= tog_nxt;
      end
   end

   // ****************************************
   // readback shift-out, msb first
   // ****************************************
   assign idx      = CNT_W'(FRAME_BITS - 1) - cnt_r;
   assign sdo      = (cnt_r < CNT_W'(FRAME_BITS)) ? rb_word[idx] : 1'b0;
   assign word     = word_r;
   assign word_tog = tog_r;
endmodule : frame_rx
`default_nettype wire

/* File: logic/level_sync.sv */
// two flip-flop synchroniser for a group of levels
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // levels
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;
   logic [W-1:0] q_r;

   always_ff @(posedge clk) begin
      if (rst) begin
         meta_r <= '0;
         q_r    <= '0;
      end else begin
         meta_r <= d;
         q_r    <= meta_r;
      end
   end

   assign q = q_r;
endmodule : level_sync
`default_nettype wire

/* File: testbench/dac_pwr_monitor.sv */
// concurrent checks on the power and fault block ports
`timescale 1ns/1ps
`default_nettype none
module dac_pwr_monitor (
   // clock and reset
   input wire logic       SYS_CLK,
   input wire logic       RESET,
   // observed pins
   input wire logic       SYNC_N,
   input wire logic       SDO_OE,
   input wire logic       SUPPLY_OK,
   input wire logic [3:0] OVERCURRENT,
   input wire logic [3:0] CHAN_POWERED,
   input wire logic [3:0] AMP_CONNECT,
   input wire logic [3:0] OUT_CLAMP,
   input wire logic [3:0] CURRENT_LIMIT,
   input wire logic       REF_POWERED
);
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (RESET);
   chk_reset_state: assert property (disable iff (1'b0)
      RESET |=> CHAN_POWERED == 4'h0 && !REF_POWERED && OUT_CLAMP == 4'hf)
      else $error("outputs not at reset state");
   chk_clamp_inverse: assert property (OUT_CLAMP == ~AMP_CONNECT)
      else $error("clamp and amplifier overlap");
   chk_amp_needs_power: assert property ((AMP_CONNECT & ~CHAN_POWERED) == 4'h0)
      else $error("amplifier on in unpowered channel");
   chk_brownout_clamp: assert property (!SUPPLY_OK [*3] |=> AMP_CONNECT == 4'h0)
      else $error("outputs not clamped without supply");
   chk_arm_supply: assert property ($rose(|AMP_CONNECT) |-> $past(SUPPLY_OK, 3))
      else $error("amplifier connected without supply");
   chk_limit_follows: assert property ((CURRENT_LIMIT & ~$past(OVERCURRENT, 3)) == 4'h0)
      else $error("current limit without fault");
   chk_auto_powerdown: assert property (
      ($past(OVERCURRENT, 3) & CHAN_POWERED & ~CURRENT_LIMIT) == 4'h0)
      else $error("faulted channel neither limited nor down");
   chk_sdo_idle: assert property (SYNC_N |-> !SDO_OE)
      else $error("readback driven outside frame");
endmodule : dac_pwr_monitor
`default_nettype wire

/* File: testbench/host_link.sv */
// host side of the serial link
`timescale 1ns/1ps
`default_nettype none
module host_link (
   // link
   output logic      SCLK,
   output logic      SYNC_N,
   output logic      SDIN,
   input  wire logic SDO
);
   // select starts low and rises, so the link bit counter clears
   initial begin
      SCLK = 1'b1;
      SYNC_N = 1'b0;
      SDIN = 1'b0;
      #10;
      SYNC_N = 1'b1;
   end
   // one 24-bit frame, msb first, readback captured before each fall
   task automatic xfer(input logic [23:0] w, output logic [23:0] r);
      #37;
      SYNC_N = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         SDIN = w[i];
         #62.5;
         r[i] = SDO;
         SCLK = 1'b0;
         #62.5;
         SCLK = 1'b1;
      end
      SYNC_N = 1'b1;
      SDIN = ~SDIN;
      #1000;
   endtask : xfer
endmodule : host_link
`default_nettype wire

/* File: testbench/tb_top.sv */
// self-checking bench for the power and fault block
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import dac_pwr_pkg::*;
;
   // ****************************************
   // signals and instances
   // ****************************************
   logic        SYS_CLK = 1'b0;
   logic        RESET = 1'b1;
   logic        OVERTEMP = 1'b0;
   logic        SUPPLY_OK = 1'b0;
   logic [3:0]  OVERCURRENT = 4'h0;
   logic        SCLK, SYNC_N, SDIN, SDO, SDO_OE, REF_POWERED;
   logic [3:0]  CHAN_POWERED, AMP_CONNECT, OUT_CLAMP, CURRENT_LIMIT;
   logic [15:0] d;
   int          mismatches = 0;
   int          comparisons = 0;
   int          seed = 32'hdc35;
   always #50 SYS_CLK = ~SYS_CLK;
   dac_power_fault_control dac_power_fault_control_inst (
      .SYS_CLK(SYS_CLK), .RESET(RESET), .SCLK(SCLK), .SYNC_N(SYNC_N), .SDIN(SDIN),
      .SDO(SDO), .SDO_OE(SDO_OE), .OVERCURRENT(OVERCURRENT), .OVERTEMP(OVERTEMP),
      .SUPPLY_OK(SUPPLY_OK), .CHAN_POWERED(CHAN_POWERED), .AMP_CONNECT(AMP_CONNECT),
      .OUT_CLAMP(OUT_CLAMP), .CURRENT_LIMIT(CURRENT_LIMIT), .REF_POWERED(REF_POWERED));
   host_link host_link_inst (.SCLK(SCLK), .SYNC_N(SYNC_N), .SDIN(SDIN), .SDO(SDO));
   // ****************************************
   // helpers
   // ****************************************
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge SYS_CLK);
   endtask : cyc
   task automatic wr(input logic [2:0] rs, input logic [2:0] ad, input logic [15:0] dt);
      logic [23:0] r;
      host_link_inst.xfer({2'b00, rs, ad, dt}, r);
   endtask : wr
   function automatic logic [15:0] pwr(logic [3:0] oc, logic ot, logic rf, logic [3:0] pu);
      return {5'h00, oc, 1'b0, ot, rf, pu};
   endfunction : pwr
   task automatic chk_rd(input logic [15:0] exp);
      logic [23:0] r;
      host_link_inst.xfer({2'b10, REG_POWER, ADDR_POWER, 16'h0000}, r);
      host_link_inst.xfer({2'b00, REG_CONTROL, 3'h0, 16'h0000}, r);
      chk(r[15:0], exp);
   endtask : chk_rd
   task automatic fault(input logic [3:0] oc, input logic ot);
      @(posedge SYS_CLK);
      OVERCURRENT <= oc;
      OVERTEMP <= ot;
      cyc(5);
   endtask : fault
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : final_report
   // ****************************************
   // tests
   // ****************************************
   initial begin
      cyc(16);
      RESET <= 1'b0;
      cyc(4);
      chk({CHAN_POWERED, AMP_CONNECT, OUT_CLAMP, CURRENT_LIMIT}, 16'h00f0);
      chk({15'h0, REF_POWERED}, 16'h0000);
      chk_rd(pwr(4'h0, 1'b0, 1'b0, 4'h0));
      $display("test reset done");
      for (int k = 0; k < 8; k++) begin
         d = (k == 0) ? 16'hffff : 16'($random(seed));
         wr(REG_POWER, ADDR_POWER, d);
         wr(REG_POWER, ADDR_CFG, ~d);
         chk({11'h0, REF_POWERED, CHAN_POWERED}, {11'h0, d[4:0]});
         chk_rd(pwr(4'h0, 1'b0, d[4], d[3:0]));
      end
      $display("test power writes done");
      wr(REG_POWER, ADDR_POWER, 16'h000f);
      chk({12'h0, AMP_CONNECT}, 16'h0000);
      @(posedge SYS_CLK);
      SUPPLY_OK <= 1'b1;
      cyc(PU_WAIT_CYCLES);
      wr(REG_DAC, 3'h4, 16'($random(seed)));
      chk({8'h0, AMP_CONNECT, OUT_CLAMP}, 16'h00f0);
      wr(REG_POWER, ADDR_POWER, 16'h0016);
      chk({8'h0, AMP_CONNECT, OUT_CLAMP}, 16'h0069);
      @(posedge SYS_CLK);
      SUPPLY_OK <= 1'b0;
      cyc(5);
      chk({12'h0, AMP_CONNECT}, 16'h0000);
      SUPPLY_OK <= 1'b1;
      $display("test output clamp done");
      wr(REG_POWER, ADDR_POWER, 16'h000f);
      fault(4'h5, 1'b0);
      chk({8'h0, CURRENT_LIMIT, CHAN_POWERED}, 16'h005f);
      chk_rd(pwr(4'h5, 1'b0, 1'b0, 4'hf));
      fault(4'h0, 1'b0);
      chk_rd(pwr(4'h0, 1'b0, 1'b0, 4'hf));
      wr(REG_CONTROL, ADDR_CFG, 16'h0000);
      fault(4'ha, 1'b0);
      chk({8'h0, CURRENT_LIMIT, CHAN_POWERED}, 16'h0005);
      chk_rd(pwr(4'ha, 1'b0, 1'b0, 4'h5));
      fault(4'h0, 1'b0);
      wr(REG_POWER, ADDR_POWER, 16'h000f);
      chk({12'h0, CHAN_POWERED}, 16'h000f);
      $display("test overcurrent done");
      fault(4'h0, 1'b1);
      chk_rd(pwr(4'h0, 1'b0, 1'b0, 4'hf));
      wr(REG_CONTROL, ADDR_CFG, 16'h000c);
      chk_rd(pwr(4'h0, 1'b1, 1'b0, 4'h0));
      fault(4'h0, 1'b0);
      chk_rd(pwr(4'h0, 1'b0, 1'b0, 4'h0));
      $display("test thermal done");
      final_report();
   end
   initial begin
      cyc(30000);
      mismatches++;
      final_report();
   end
endmodule : tb_top
bind dac_power_fault_control dac_pwr_monitor dac_pwr_monitor_inst (
   .SYS_CLK(SYS_CLK), .RESET(RESET), .SYNC_N(SYNC_N), .SDO_OE(SDO_OE),
   .SUPPLY_OK(SUPPLY_OK), .OVERCURRENT(OVERCURRENT), .CHAN_POWERED(CHAN_POWERED),
   .AMP_CONNECT(AMP_CONNECT), .OUT_CLAMP(OUT_CLAMP), .CURRENT_LIMIT(CURRENT_LIMIT),
   .REF_POWERED(REF_POWERED));
`default_nettype wire
